// ### shms_defs.svh
`ifndef SHMS_DEFS_SVH
`define SHMS_DEFS_SVH
// ==========================================================
// Method numbers
`define SHMS_M_LIMIT_REV 8'h01
`define SHMS_M_LIMIT_FWD 8'h02
`define SHMS_M_DOG_FIRST 8'h03
`define SHMS_M_REVERSE_FIRST 8'h07
`define SHMS_M_BASE_LAST 8'h0E
`define SHMS_M_NOIDX_OFS 8'h10
`define SHMS_M_NOIDX_FIRST 8'h11
`define SHMS_M_NOIDX_LAST 8'h1E
`define SHMS_M_INDEX_REV 8'h21
`define SHMS_M_INDEX_FWD 8'h22
`define SHMS_M_CURPOS_A 8'h23
`define SHMS_M_CURPOS_B 8'h25
// ==========================================================
// Widths, reset values and sensor slots
`define SHMS_POS_W 32
`define SHMS_POS_RESET 32'h00000000
`define SHMS_NUM_SRC 4
`define SHMS_SRC_DOG 2
`define SHMS_SRC_INDEX 3
`endif

// ### shms_pkg.sv
`include "shms_defs.svh"
package shms_pkg;
   typedef struct packed {
      logic valid;
      logic useIndex;
      logic limitRef;
      logic refLast;
      logic mayReverse;
      logic startFwd;
      logic creepStart;
      logic current;
   } shms_method_t;

   typedef enum logic [5:0] {
      ST_IDLE = 6'b000001,
      ST_SEEK = 6'b000010,
      ST_DOG = 6'b000100,
      ST_AWAY = 6'b001000,
      ST_ZSEEK = 6'b010000,
      ST_SHIFT = 6'b100000
   } shms_state_t;

   typedef struct packed {
      logic [`SHMS_NUM_SRC-1:0] rise;
      logic [`SHMS_NUM_SRC-1:0] fall;
   } shms_edges_t;
endpackage

// ### shms_edge_detect.sv
`include "shms_defs.svh"
module shms_edge_detect
   import shms_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [`SHMS_NUM_SRC-1:0] level,
   output shms_edges_t edges
);
   logic [`SHMS_NUM_SRC-1:0] prev;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         prev <= '0;
      end else begin
         prev <= level;
      end
   end

   // ==========================================================
   // Edges per sensor
   genvar i;
   generate
      for (i = 0; i < `SHMS_NUM_SRC; i++) begin : g_src
         assign edges.rise[i] = level[i] & ~prev[i];
         assign edges.fall[i] = ~level[i] & prev[i];
      end
   endgenerate
endmodule

// ### shms_sequencer.sv
// How it works
// [R01] Methods 7,8,11,12: home as 3-6, reverse
// [R02] Method 7: last index inside home switch
// [R03] Method 8: forward start, index after switch
// [R04] 7,8 start forward; 11,12 start reverse
// [R05] Methods 9,10 search forward with index
// [R06] Method 9: index before switch trailing edge
// [R07] Method 10: index after switch trailing edge
// [R08] 9,10: forward limit reverses the search
// [R09] Methods 13,14 mirror 9,10 start direction
// [R10] 17-30 move as 1-14, edge homes
// [R11] Method 19: home at switch front edge
// [R12] Method 20: home at switch rear edge
// [R13] 33,34: first index, creep from start
// [R14] 35,37: current position, servo off allowed
// [R15] Direction select 1 with polarity reflect set mirrors all searches
// [R16] Mirror applies only with polarity reflect set
// [R17] Method 1 searches opposite to method 2
// [R18] Installer: limit half turn from index
// [R19] Methods 1,2 refused with software limits
// [R20] Opposite limit before index raises warning
// [R21] Then shift by offset at creep, complete
`include "shms_defs.svh"
module shms_sequencer
   import shms_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic startHoming,
   input wire logic [7:0] homingMethod,
   input wire logic travelDirectionSelect,
   input wire logic homingPolarityReflect,
   input wire logic servoOn,
   input wire logic softLimitMode,
   input wire logic limitFwd,
   input wire logic limitRev,
   input wire logic homeSwitch,
   input wire logic indexPulse,
   input wire logic [`SHMS_POS_W-1:0] position,
   input wire logic [`SHMS_POS_W-1:0] homeOffset,
   output logic moveFwd,
   output logic moveRev,
   output logic creepSpeed,
   output logic busy,
   output logic homeDone,
   output logic homeAttained,
   output logic homingIncompleteWarning,
   output logic methodRefused,
   output logic [`SHMS_POS_W-1:0] homePosition
);
   // ==========================================================
   // Method decode
   function automatic shms_method_t decodeMethod(input logic [7:0] m);
      shms_method_t d;
      logic [7:0] b;
      d = '0;
      b = m;
      if (m >= `SHMS_M_NOIDX_FIRST && m <= `SHMS_M_NOIDX_LAST) begin
         b = m - `SHMS_M_NOIDX_OFS; // [R10]
      end
      if (m == `SHMS_M_INDEX_REV || m == `SHMS_M_INDEX_FWD) begin
         d.valid = 1'b1; // [R13]
         d.useIndex = 1'b1;
         d.creepStart = 1'b1;
         d.startFwd = (m == `SHMS_M_INDEX_FWD);
      end else if (m == `SHMS_M_CURPOS_A || m == `SHMS_M_CURPOS_B) begin
         d.valid = 1'b1; // [R14]
         d.current = 1'b1;
      end else if (b >= `SHMS_M_LIMIT_REV && b <= `SHMS_M_BASE_LAST) begin
         d.valid = 1'b1;
         d.useIndex = (m <= `SHMS_M_BASE_LAST); // [R10]
         d.limitRef = (b <= `SHMS_M_LIMIT_FWD);
         // Odd dog methods reference the switch region before its end
         d.refLast = b[0] && (b >= `SHMS_M_DOG_FIRST); // [R02] [R06]
         d.mayReverse = (b >= `SHMS_M_REVERSE_FIRST); // [R01] [R08]
         case (b)
            8'h02, 8'h03, 8'h04, 8'h07, 8'h08, 8'h09, 8'h0A: begin
               d.startFwd = 1'b1; // [R04] [R05] [R09] [R17]
            end
            default: begin
               d.startFwd = 1'b0;
            end
         endcase
      end
      return d;
   endfunction

   // ==========================================================
   // Sensor edges
   shms_edges_t edges;
   logic idxRise;
   logic dogFall;

   shms_edge_detect u_edges (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .level({indexPulse, homeSwitch, limitRev, limitFwd}),
      .edges(edges)
   );

   assign idxRise = edges.rise[`SHMS_SRC_INDEX];
   assign dogFall = edges.fall[`SHMS_SRC_DOG];

   // ==========================================================
   // Working state
   shms_state_t state;
   shms_method_t cfg;
   logic dir;
   logic mirror;
   logic reversed;
   logic haveCand;
   logic [`SHMS_POS_W-1:0] candidate;
   logic [`SHMS_POS_W-1:0] target;

   shms_method_t newCfg;
   logic newMirror;
   logic logLimF;
   logic logLimR;
   logic limAhead;
   logic limBehind;
   logic accept;

   assign newCfg = decodeMethod(homingMethod);
   assign newMirror = travelDirectionSelect & homingPolarityReflect; // [R15] [R16]
   // Limits seen in the logical frame so mirroring needs no special case
   assign logLimF = mirror ? limitRev : limitFwd; // [R15]
   assign logLimR = mirror ? limitFwd : limitRev;
   assign limAhead = dir ? logLimF : logLimR;
   assign limBehind = dir ? logLimR : logLimF;
   // Software limits give no physical edge to creep away from
   assign accept = newCfg.valid && (newCfg.current || servoOn) &&
      !(newCfg.limitRef && newCfg.useIndex && softLimitMode); // [R14] [R19]

   // ==========================================================
   // Next-state decision
   shms_state_t next_state;
   logic next_dir;
   logic next_creep;
   logic next_reversed;
   logic doLatch;
   logic [`SHMS_POS_W-1:0] latchVal;
   logic doFail;
   logic doneNow;

   always_comb begin
      next_state = state;
      next_dir = dir;
      next_creep = creepSpeed;
      next_reversed = reversed;
      doLatch = 1'b0;
      latchVal = position;
      doFail = 1'b0;
      doneNow = 1'b0;
      case (state)
         ST_IDLE: begin
            if (startHoming && accept && newCfg.current) begin
               doLatch = 1'b1; // [R14]
               doneNow = 1'b1;
            end else if (startHoming && accept) begin
               next_dir = newCfg.startFwd; // [R04]
               next_creep = newCfg.creepStart; // [R13]
               next_reversed = 1'b0;
               next_state = newCfg.creepStart ? ST_ZSEEK : ST_SEEK;
            end
         end
         ST_SEEK: begin
            if (cfg.limitRef && limAhead) begin
               next_dir = ~dir; // [R17]
               next_creep = 1'b1;
               next_state = ST_AWAY;
            end else if (!cfg.limitRef && homeSwitch) begin
               next_creep = 1'b1;
               if (!cfg.useIndex && cfg.refLast) begin
                  doLatch = 1'b1; // [R11]
                  next_state = ST_SHIFT;
               end else begin
                  next_state = ST_DOG;
               end
            end else if (limAhead && cfg.mayReverse && !reversed) begin
               next_dir = ~dir; // [R01] [R08]
               next_reversed = 1'b1;
            end else if (limAhead) begin
               doFail = 1'b1;
            end
         end
         ST_DOG: begin
            if (dogFall) begin
               if (!cfg.useIndex) begin
                  doLatch = 1'b1; // [R12]
                  next_state = ST_SHIFT;
               end else if (cfg.refLast) begin
                  // Last index inside the switch region
                  latchVal = idxRise ? position : candidate; // [R02] [R06]
                  doLatch = idxRise || haveCand;
                  doFail = !(idxRise || haveCand);
                  next_state = doLatch ? ST_SHIFT : ST_IDLE;
               end else begin
                  next_state = ST_ZSEEK; // [R03] [R07]
               end
            end else if (limAhead && cfg.mayReverse && !reversed) begin
               next_dir = ~dir; // [R08]
               next_reversed = 1'b1;
            end else if (limAhead) begin
               doFail = 1'b1;
            end
         end
         ST_AWAY: begin
            if (cfg.useIndex && idxRise) begin
               doLatch = 1'b1; // [R17]
               next_state = ST_SHIFT;
            end else if (!cfg.useIndex && !limBehind) begin
               doLatch = 1'b1; // [R10]
               next_state = ST_SHIFT;
            end else if (limAhead) begin
               doFail = 1'b1; // [R20]
            end
         end
         ST_ZSEEK: begin
            if (idxRise) begin
               doLatch = 1'b1; // [R07] [R13]
               next_state = ST_SHIFT;
            end else if (limAhead) begin
               doFail = 1'b1; // [R20]
            end
         end
         ST_SHIFT: begin
            next_creep = 1'b1; // [R21]
            if (position == target) begin
               doneNow = 1'b1; // [R21]
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      if (doFail || doneNow) begin
         next_state = ST_IDLE;
      end
   end

   // ==========================================================
   // Sequencer registers
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         dir <= 1'b0;
         reversed <= 1'b0;
         creepSpeed <= 1'b0;
      end else begin
         state <= next_state;
         dir <= next_dir;
         reversed <= next_reversed;
         creepSpeed <= (next_state == ST_IDLE) ? 1'b0 : next_creep;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cfg <= '0;
         mirror <= 1'b0;
      end else if (state == ST_IDLE && startHoming && accept) begin
         cfg <= newCfg;
         mirror <= newMirror; // [R16]
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         candidate <= `SHMS_POS_RESET;
         haveCand <= 1'b0;
      end else if (state != ST_DOG) begin
         haveCand <= 1'b0;
      end else if (idxRise) begin
         candidate <= position; // [R02] [R06]
         haveCand <= 1'b1;
      end
   end

   // Offset is applied after the reference, so a negative offset
   // first reaches the reference and then backs off
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         homePosition <= `SHMS_POS_RESET;
         target <= `SHMS_POS_RESET;
      end else if (doLatch) begin
         homePosition <= latchVal;
         target <= cfg.current ? latchVal : latchVal + homeOffset; // [R21]
         if (state == ST_IDLE) begin
            target <= latchVal; // [R14]
         end
      end
   end

   // ==========================================================
   // Motion outputs, physical frame
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         moveFwd <= 1'b0;
         moveRev <= 1'b0;
         busy <= 1'b0;
      end else begin
         busy <= (next_state != ST_IDLE);
         if (next_state == ST_IDLE) begin
            moveFwd <= 1'b0;
            moveRev <= 1'b0;
         end else if (next_state == ST_SHIFT) begin
            moveFwd <= $signed(position) < $signed(doLatch ?
               latchVal + homeOffset : target); // [R21]
            moveRev <= $signed(position) > $signed(doLatch ?
               latchVal + homeOffset : target);
         end else begin
            moveFwd <= next_dir ^ (state == ST_IDLE ? newMirror : mirror);
            moveRev <= ~(next_dir ^ (state == ST_IDLE ? newMirror : mirror));
         end
      end
   end

   // ==========================================================
   // Status outputs
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         homeDone <= 1'b0;
         homeAttained <= 1'b0;
         homingIncompleteWarning <= 1'b0;
         methodRefused <= 1'b0;
      end else begin
         homeDone <= doneNow;
         methodRefused <= (state == ST_IDLE) && startHoming && !accept;
         if (doneNow) begin
            homeAttained <= 1'b1;
         end else if (state == ST_IDLE && startHoming && accept) begin
            homeAttained <= 1'b0;
         end
         if (doFail) begin
            homingIncompleteWarning <= 1'b1; // [R20]
         end else if (state == ST_IDLE && startHoming && accept) begin
            homingIncompleteWarning <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   a_servo_off_refuse: assert property ( // [R14]
      state == ST_IDLE && startHoming && newCfg.valid && !newCfg.current
      && !servoOn |=> methodRefused && !busy)
      else $error("start accepted with servo off");
   a_current_home: assert property ( // [R14]
      state == ST_IDLE && startHoming && newCfg.current
      |=> homeAttained && homeDone && homePosition == $past(position))
      else $error("current position not taken as home");
   a_soft_limit: assert property ( // [R19]
      state == ST_IDLE && startHoming && softLimitMode && newCfg.valid
      && newCfg.limitRef && newCfg.useIndex |=> methodRefused)
      else $error("limit method accepted with software limits");
   a_start_dir: assert property ( // [R15]
      state == ST_IDLE && startHoming && accept && !newCfg.current
      |=> moveFwd == ($past(newCfg.startFwd) ^ $past(newMirror)))
      else $error("wrong start direction");
   a_limit_reverse: assert property ( // [R08]
      state == ST_SEEK && !cfg.limitRef && !homeSwitch && limAhead
      && cfg.mayReverse && !reversed |=> dir != $past(dir) && busy)
      else $error("no reversal at limit");
   a_index_latch: assert property ( // [R13]
      state == ST_ZSEEK && idxRise |=> state == ST_SHIFT
      && homePosition == $past(position))
      else $error("index not latched");
   a_away_warn: assert property ( // [R20]
      state == ST_AWAY && cfg.useIndex && !idxRise && limAhead
      |=> homingIncompleteWarning && !busy ##1 !moveFwd && !moveRev)
      else $error("opposite limit did not warn");
   a_shift_done: assert property ( // [R21]
      state == ST_SHIFT && position == target
      |=> homeDone && homeAttained ##1 !homeDone)
      else $error("shift did not complete");
   a_shift_creep: assert property ( // [R21]
      state == ST_SHIFT |-> creepSpeed && busy)
      else $error("shift not at creep speed");
endmodule

// ### shms_ctrl_model.sv
module shms_ctrl_model (
   input wire logic clk_sys,
   input wire logic busy,
   input wire logic homeDone,
   input wire logic methodRefused,
   output logic startHoming,
   output logic [7:0] homingMethod
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      startHoming = 1'b0;
      homingMethod = 8'h00;
   end

   // ==========================================================
   // Start request
   // Held for exactly one taking edge, so a level never restarts a run
   task automatic request(input logic [7:0] m, output logic ok);
      int n;
      @(posedge clk_sys);
      startHoming <= 1'b1;
      homingMethod <= m;
      @(posedge clk_sys);
      startHoming <= 1'b0;
      ok = 1'b0;
      for (n = 0; n < 4 && !ok; n++) begin
         #1;
         ok = busy | homeDone | methodRefused;
         if (!ok)
            @(posedge clk_sys);
      end
   endtask
endmodule

// ### tb.sv
`include "shms_defs.svh"
module tb
   import shms_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   localparam int START = 5;
   localparam int LIM_F = 296;
   localparam int LIM_R = -200;
   localparam int DOG_LO = 100;
   localparam int DOG_HI = 140;
   localparam int LIMIT = 100000;
   localparam int BAD[8] = '{0, 15, 16, 31, 32, 36, 38, 255};

   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic travelDirectionSelect = 1'b0;
   logic homingPolarityReflect = 1'b0;
   logic servoOn = 1'b1;
   logic softLimitMode = 1'b0;
   logic idxEn = 1'b1;
   logic hitTgt = 1'b0;
   logic signed [`SHMS_POS_W-1:0] position = START;
   logic [`SHMS_POS_W-1:0] homeOffset = 32'h00000000;
   logic [`SHMS_POS_W-1:0] homePosition;
   logic startHoming, moveFwd, moveRev, creepSpeed, busy, homeDone;
   logic homeAttained, homingIncompleteWarning, methodRefused;
   logic [7:0] homingMethod;
   logic [31:0] seed = 32'h00012398;
   int tgt = 0;
   int lastPos = 0;
   int errors = 0;
   int checks = 0;
   int cycles = 0;

   always #50 clk_sys = ~clk_sys;

   // ==========================================================
   // Axis: one count per cycle, index every 16 counts
   // Limits sit half an index period from the nearest index
   wire limitFwd = position >= LIM_F;
   wire limitRev = position <= LIM_R;
   wire homeSwitch = position >= DOG_LO && position <= DOG_HI;
   wire indexPulse = idxEn && position[3:0] == 4'h0;

   always @(posedge clk_sys) begin
      if (moveFwd)
         position <= position + 1;
      else if (moveRev)
         position <= position - 1;
      // Position the sequencer saw on the edge that raised homeDone, so a
      // search that merely passes the target does not count
      lastPos <= position;
      if (homeDone && lastPos == tgt)
         hitTgt <= 1'b1;
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         errors++;
         wrap_up();
      end
   end

   shms_ctrl_model ctrl (
      .clk_sys(clk_sys),
      .busy(busy),
      .homeDone(homeDone),
      .methodRefused(methodRefused),
      .startHoming(startHoming),
      .homingMethod(homingMethod)
   );

   shms_sequencer dut (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .startHoming(startHoming),
      .homingMethod(homingMethod),
      .travelDirectionSelect(travelDirectionSelect),
      .homingPolarityReflect(homingPolarityReflect),
      .servoOn(servoOn),
      .softLimitMode(softLimitMode),
      .limitFwd(limitFwd),
      .limitRev(limitRev),
      .homeSwitch(homeSwitch),
      .indexPulse(indexPulse),
      .position(position),
      .homeOffset(homeOffset),
      .moveFwd(moveFwd),
      .moveRev(moveRev),
      .creepSpeed(creepSpeed),
      .busy(busy),
      .homeDone(homeDone),
      .homeAttained(homeAttained),
      .homingIncompleteWarning(homingIncompleteWarning),
      .methodRefused(methodRefused),
      .homePosition(homePosition)
   );

   // ==========================================================
   // Helpers
   function automatic int rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return int'(seed & 32'h7FFFFFFF);
   endfunction

   // Expected home from the axis layout; dog lies on the positive side
   function automatic void predict(input int m, input logic mir,
         output int hp, output logic warn, output logic fwd);
      int b;
      logic ni;
      ni = m > 16 && m < 31;
      b = ni ? m - 16 : m;
      fwd = mir ^ (b == 2 || b == 3 || b == 4 || b == 7 || b == 8 ||
         b == 9 || b == 10 || b == 34);
      warn = 1'b0;
      hp = START;
      if (b == 1 || b == 2)
         hp = fwd ? (ni ? LIM_F - 1 : 288) : (ni ? LIM_R + 1 : -192);
      else if (b >= 3 && b <= 14) begin
         warn = !fwd && b < 7;
         hp = b % 2 ? (ni ? DOG_LO : 128) : (ni ? DOG_HI + 1 : 144);
      end else if (b == 33 || b == 34)
         hp = fwd ? 16 : 0;
   endfunction

   task automatic check(input string what, input logic [31:0] seen,
         input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wrap_up();
      if (errors == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic run(input int m, input logic sel, input logic refl,
         input int ofs);
      int hp, n;
      logic warn, fwd, ok;
      predict(m, sel & refl, hp, warn, fwd);
      warn = warn | !idxEn;
      @(posedge clk_sys);
      position <= START;
      travelDirectionSelect <= sel;
      homingPolarityReflect <= refl;
      homeOffset <= 32'(ofs);
      tgt = hp + ofs;
      hitTgt <= 1'b0;
      ctrl.request(m[7:0], ok);
      check("answer", ok, 1'b1);
      if (m == 35 || m == 37) begin
         check("done", homeDone, 1'b1);
         check("busy", busy, 1'b0);
      end else begin
         check("fwd", moveFwd, fwd);
         check("rev", moveRev, !fwd);
         check("creep", creepSpeed, m > 32);
         check("warn clear", homingIncompleteWarning, 1'b0);
         for (n = 0; n < 3000 && busy !== 1'b0; n++)
            @(posedge clk_sys);
         #1;
         check("finished", busy, 1'b0);
      end
      check("warning", homingIncompleteWarning, warn);
      if (!warn) begin
         check("home", homePosition, 32'(hp));
         check("attained", homeAttained, 1'b1);
         if (m < 35)
            check("target", hitTgt, 1'b1);
      end
   endtask

   task automatic refuse(input int m);
      logic ok;
      ctrl.request(m[7:0], ok);
      check("refused", methodRefused, 1'b1);
      check("idle", busy, 1'b0);
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      int i, m;
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      for (m = 1; m < 35; m++)
         if (m % 16 != 15 && m % 16 != 0)
            run(m, 1'b0, 1'b0, 0);
      run(7, 1'b1, 1'b0, 0);
      run(7, 1'b1, 1'b1, 0);
      run(9, 1'b1, 1'b1, 2);
      run(3, 1'b1, 1'b1, 0);
      servoOn <= 1'b0;
      run(35, 1'b0, 1'b0, 0);
      run(37, 1'b1, 1'b1, 0);
      refuse(3);
      servoOn <= 1'b1;
      softLimitMode <= 1'b1;
      refuse(1);
      refuse(2);
      run(4, 1'b0, 1'b0, -3);
      softLimitMode <= 1'b0;
      for (i = 0; i < 8; i++)
         refuse(BAD[i]);
      idxEn = 1'b0;
      run(2, 1'b0, 1'b0, 0);
      run(33, 1'b0, 1'b0, 0);
      idxEn = 1'b1;
      for (i = 0; i < 30; i++) begin
         m = 1 + rnd() % 34;
         if (m % 16 == 15 || m % 16 == 0)
            m = 34;
         run(m, rnd() % 2, rnd() % 2, rnd() % 15 - 7);
      end
      wrap_up();
   end
endmodule
